// >>> src/pcm_edge.sv
// Falling edge detector for a synchronous input
module pcm_edge (
   input  wire logic CLK_SYS,
   input  wire logic RST_B,
   input  wire logic din,
   output logic      fall
);
   logic prev_r;

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         prev_r <= 1'b1;
      end else begin
         prev_r <= din;
      end
   end

   assign fall = prev_r & ~din;
endmodule // pcm_edge

// >>> src/pcm_pkg.sv
// Constants and types of the counter-array mode control block
package pcm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses on the bus
   localparam logic [7:0] ADDR_MODE    = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h04;
   localparam logic [7:0] ADDR_STATUS  = 8'h08;
   localparam logic [7:0] ADDR_IRQ_EN  = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
   localparam logic [7:0] ADDR_COUNT   = 8'h14;

   ////////////////////////////////////////////////////////////////////////////
   // Mode register fields and reset value
   localparam int         MODE_IDLE_BIT = 7;
   localparam int         MODE_PS_LSB   = 1;
   localparam int         MODE_OVF_BIT  = 0;
   localparam logic [7:0] MODE_RESET    = 8'h00;
   localparam logic [7:0] MODE_WMASK    = 8'h8F;

   ////////////////////////////////////////////////////////////////////////////
   // Status bit layout: 0 overflow, 1 module 0, 2 module 1
   localparam int         NUM_EVT      = 3;
   localparam int         EVT_OVF      = 0;
   localparam int         EVT_M0       = 1;
   localparam int         EVT_M1       = 2;
   localparam logic [2:0] EVT_RESET    = 3'h0;
   localparam logic [15:0] COUNT_RESET = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Timebase division counts
   localparam int         DIV_SLOW     = 12;
   localparam int         DIV_FAST     = 4;
   localparam int         DIV_EXT      = 8;
   localparam logic [3:0] DIV_SLOW_END = 4'(DIV_SLOW - 1);
   localparam logic [1:0] DIV_FAST_END = 2'(DIV_FAST - 1);
   localparam logic [2:0] DIV_EXT_END  = 3'(DIV_EXT - 1);

   typedef enum logic [2:0] {
      PS_CLK12, PS_CLK4, PS_T0OVF, PS_EXTIN, PS_CLK, PS_EXT8, PS_RSV6, PS_RSV7
   } pcm_src_e;

endpackage

// >>> src/pcm_prescale.sv
// Modulo prescaler producing a one-cycle enable
module pcm_prescale #(
   parameter int W = 4,
   parameter logic [W-1:0] LAST = '1
) (
   input  wire logic CLK_SYS,
   input  wire logic RST_B,
   input  wire logic step,
   output logic      tick
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         wrap;

   assign wrap    = step && (cnt_r == LAST);
   assign cnt_nxt = wrap ? '0 : W'(cnt_r + 1'b1);
   assign tick    = wrap;

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         cnt_r <= '0;
      end else if (step) begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule // pcm_prescale

// >>> src/pcm_top.sv
// Counter-array mode control with timebase selection and AHB-Lite registers
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
module pcm_top (
   input  wire logic        CLK_SYS,
   input  wire logic        RST_B,
   input  wire logic        HSEL,
   input  wire logic [7:0]  HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        CPU_IDLE,
   input  wire logic        TIMER0_OVF,
   input  wire logic        EXT_COUNT_INPUT,
   input  wire logic        EXT_CLOCK,
   input  wire logic        MODULE0_MATCH,
   input  wire logic        MODULE1_MATCH,
   output logic             COUNT_TICK,
   output logic [15:0]      COUNT_VALUE,
   output logic             IRQ
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus address phase capture
   logic       wr_pend_r;
   logic       rd_pend_r;
   logic [7:0] addr_r;
   logic       phase_ok;

   assign phase_ok  = HSEL && HREADY && HTRANS[1];
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         addr_r    <= 8'h00;
      end else begin
         wr_pend_r <= phase_ok && HWRITE;
         rd_pend_r <= phase_ok && !HWRITE;
         if (phase_ok) begin
            addr_r <= HADDR;
         end
      end
   end

   wire wr_mode  = wr_pend_r && (addr_r == pcm_pkg::ADDR_MODE);
   wire wr_ctrl  = wr_pend_r && (addr_r == pcm_pkg::ADDR_CONTROL);
   wire wr_en    = wr_pend_r && (addr_r == pcm_pkg::ADDR_IRQ_EN);
   wire wr_clr   = wr_pend_r && (addr_r == pcm_pkg::ADDR_IRQ_CLR);

   ////////////////////////////////////////////////////////////////////////////
   // Mode register
   logic [7:0] mode_r;
   logic [2:0] irq_en_r;

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         mode_r   <= pcm_pkg::MODE_RESET;
         irq_en_r <= pcm_pkg::EVT_RESET;
      end else begin
         if (wr_mode) begin
            mode_r <= HWDATA[7:0] & pcm_pkg::MODE_WMASK;
         end
         if (wr_en) begin
            irq_en_r <= HWDATA[2:0];
         end
      end
   end

   wire [2:0] src_sel   = mode_r[pcm_pkg::MODE_PS_LSB +: 3];
   wire       idle_ctl  = mode_r[pcm_pkg::MODE_IDLE_BIT];
   wire       ovf_en    = mode_r[pcm_pkg::MODE_OVF_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Timebase sources
   // CPU idle suspends operation only when the mode idle bit (bit 7) is set
   wire run = !(idle_ctl && CPU_IDLE);

   logic tick12;
   logic tick4;
   logic tick_ext8;
   logic eci_fall;
   logic ext_rise;

   pcm_prescale #(.W(4), .LAST(pcm_pkg::DIV_SLOW_END)) u_div12 (
      .CLK_SYS (CLK_SYS),
      .RST_B   (RST_B),
      .step    (run),
      .tick    (tick12)
   );

   pcm_prescale #(.W(2), .LAST(pcm_pkg::DIV_FAST_END)) u_div4 (
      .CLK_SYS (CLK_SYS),
      .RST_B   (RST_B),
      .step    (run),
      .tick    (tick4)
   );

   // falling edges of the count input
   pcm_edge u_eci (
      .CLK_SYS (CLK_SYS),
      .RST_B   (RST_B),
      .din     (EXT_COUNT_INPUT),
      .fall    (eci_fall)
   );

   // External clock sampled, rising edges counted then divided
   logic ext_d_r;
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         ext_d_r <= 1'b0;
      end else begin
         ext_d_r <= EXT_CLOCK;
      end
   end
   assign ext_rise = EXT_CLOCK & ~ext_d_r;

   pcm_prescale #(.W(3), .LAST(pcm_pkg::DIV_EXT_END)) u_div8 (
      .CLK_SYS (CLK_SYS),
      .RST_B   (RST_B),
      .step    (run && ext_rise),
      .tick    (tick_ext8)
   );

   logic src_tick;
   always_comb begin
      case (pcm_pkg::pcm_src_e'(src_sel))
         pcm_pkg::PS_CLK12: src_tick = tick12;
         pcm_pkg::PS_CLK4:  src_tick = tick4;
         pcm_pkg::PS_T0OVF: src_tick = TIMER0_OVF;
         pcm_pkg::PS_EXTIN: src_tick = eci_fall;
         pcm_pkg::PS_CLK:   src_tick = 1'b1;
         pcm_pkg::PS_EXT8:  src_tick = tick_ext8;
         default:           src_tick = 1'b0;
      endcase
   end

   wire cnt_tick = src_tick && run;
   assign COUNT_TICK = cnt_tick;

   ////////////////////////////////////////////////////////////////////////////
   // Counter, flags and interrupt
   logic [15:0] count_r;
   logic [2:0]  flags_r;
   logic [2:0]  flags_nxt;
   wire         ovf_evt = cnt_tick && !wr_ctrl && (count_r == 16'hFFFF);
   wire  [2:0]  evt     = {MODULE1_MATCH && run, MODULE0_MATCH && run, ovf_evt};
   wire  [2:0]  clr     = wr_clr ? HWDATA[2:0] : 3'h0;

   // set wins over software clear, no hardware clear
   assign flags_nxt = (flags_r & ~clr) | evt;

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         count_r <= pcm_pkg::COUNT_RESET;
         flags_r <= pcm_pkg::EVT_RESET;
      end else begin
         if (wr_ctrl) begin
            count_r <= HWDATA[15:0];
         end else if (cnt_tick) begin
            count_r <= count_r + 16'h0001;
         end
         flags_r <= flags_nxt;
      end
   end

   assign COUNT_VALUE = count_r;

   // overflow enable gates interrupt, not flag
   // Enable bit 0 is storage only: the mode bit alone unmasks overflow
   wire [2:0] en_eff = {irq_en_r[2:1], ovf_en};
   assign IRQ = |(flags_r & en_eff);

   ////////////////////////////////////////////////////////////////////////////
   // Read data
   logic [31:0] rdata_r;
   wire  [31:0] rd_mux =
      (HADDR == pcm_pkg::ADDR_MODE)    ? {24'h00_0000, mode_r} :
      (HADDR == pcm_pkg::ADDR_STATUS)  ? {29'h0000_0000, flags_r} :
      (HADDR == pcm_pkg::ADDR_IRQ_EN)  ? {29'h0000_0000, irq_en_r} :
      (HADDR == pcm_pkg::ADDR_COUNT)   ? {16'h0000, count_r} : 32'h0000_0000;

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         rdata_r <= 32'h0000_0000;
      end else if (phase_ok && !HWRITE) begin
         rdata_r <= rd_mux;
      end
   end
   assign HRDATA = rdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_idle_stops: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (idle_ctl && CPU_IDLE) |-> !COUNT_TICK)
      else $error("count advanced while idle suspended");

   chk_clock_src: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (src_sel == 3'h4 && run && !wr_ctrl) |=> (count_r == $past(count_r) + 16'h0001))
      else $error("system clock source did not count");

   chk_reserved_src: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (src_sel[2:1] == 2'b11) |-> !COUNT_TICK)
      else $error("reserved source counted");

   chk_eci_fall: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (src_sel == 3'h3 && run && $fell(EXT_COUNT_INPUT)) |-> COUNT_TICK)
      else $error("falling edge not counted");

   chk_ovf_irq: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (ovf_en && flags_r[0]) |-> IRQ)
      else $error("overflow interrupt missing");

   chk_flag_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (flags_r[1] && !(wr_clr && HWDATA[1])) |=> flags_r[1])
      else $error("module flag cleared without write");

   chk_match_sets: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (MODULE0_MATCH && run) |=> flags_r[1])
      else $error("match did not set flag");

   chk_div12_gap: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      tick12 |=> (!tick12) [*8])
      else $error("divide by 12 ticks too close");

   // Running cycles since the last divide-by-12 tick
   logic [3:0] gap12_r;

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         gap12_r <= 4'h0;
      end else if (tick12) begin
         gap12_r <= 4'h0;
      end else if (run) begin
         gap12_r <= gap12_r + 4'h1;
      end
   end

   chk_div12_period: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      tick12 |-> (gap12_r == pcm_pkg::DIV_SLOW_END))
      else $error("divide by 12 period wrong");

   chk_div4_gap: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      tick4 |=> (!tick4) [*3])
      else $error("divide by 4 ticks too close");

   chk_div4_src: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (src_sel == 3'h1 && run) |-> (COUNT_TICK == tick4))
      else $error("divide by 4 source not followed");

   chk_t0_src: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (src_sel == 3'h2 && run) |-> (COUNT_TICK == TIMER0_OVF))
      else $error("timer overflow source not followed");

   chk_extin_only: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (src_sel == 3'h3) |-> (COUNT_TICK == (eci_fall && run)))
      else $error("count input source miscounted");

   chk_ext8_src: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (src_sel == 3'h5 && run) |-> (COUNT_TICK == tick_ext8))
      else $error("external clock source not followed");

   chk_ext8_gap: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      tick_ext8 |=> (!tick_ext8) [*8])
      else $error("external divide ticks too close");

   chk_count_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (!COUNT_TICK && !wr_ctrl) |=> (count_r == $past(count_r)))
      else $error("counter moved without a tick");

   chk_ovf_sets: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      ovf_evt |=> flags_r[pcm_pkg::EVT_OVF])
      else $error("overflow did not set flag");

   chk_irq_masked: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (!ovf_en && ((flags_r[2:1] & irq_en_r[2:1]) == 2'b00)) |-> !IRQ)
      else $error("masked interrupt raised");

   chk_irq_level: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (flags_r[1] && irq_en_r[1]) |-> IRQ)
      else $error("module interrupt missing");

   chk_m1_sets: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (MODULE1_MATCH && run) |=> flags_r[2])
      else $error("second match did not set flag");

   chk_m1_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (flags_r[2] && !(wr_clr && HWDATA[2])) |=> flags_r[2])
      else $error("second module flag cleared without write");

   chk_idle_no_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
      (!run && !flags_r[1]) |=> !flags_r[1])
      else $error("flag set while suspended");

   cov_ovf:  cover property (@(posedge CLK_SYS) disable iff (!RST_B) ovf_evt);
   cov_eci:  cover property (@(posedge CLK_SYS) disable iff (!RST_B) eci_fall && cnt_tick);
   cov_clr:  cover property (@(posedge CLK_SYS) disable iff (!RST_B) wr_clr && (|flags_r));
   cov_idle: cover property (@(posedge CLK_SYS) disable iff (!RST_B) idle_ctl && CPU_IDLE);
   cov_ext8: cover property (@(posedge CLK_SYS) disable iff (!RST_B) tick_ext8);

endmodule // pcm_top

// >>> verif/tb.sv
// Self-checking bench of the counter-array mode control block
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_sys = 1'b0;
   logic        rst_b   = 1'b0;
   logic        hsel    = 1'b0;
   logic [7:0]  haddr   = 8'h00;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [31:0] hwdata  = 32'h0000_0000;
   logic        idle    = 1'b0;
   logic        t0      = 1'b0;
   logic        ext_count_input     = 1'b1;
   logic        eclk    = 1'b0;
   logic        m0      = 1'b0;
   logic        m1      = 1'b0;
   wire  [31:0] hrdata;
   wire         hready;
   wire         tick;
   wire  [15:0] cval;
   wire         irq;
   wire         hresp;
   int          fails      = 0;
   int          num_checks = 0;
   int          cycles     = 0;

   always #10 clk_sys = ~clk_sys;

   pcm_top pcm_top_i (.CLK_SYS(clk_sys), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .CPU_IDLE(idle), .TIMER0_OVF(t0),
      .EXT_COUNT_INPUT(ext_count_input), .EXT_CLOCK(eclk), .MODULE0_MATCH(m0), .MODULE1_MATCH(m1),
      .COUNT_TICK(tick), .COUNT_VALUE(cval), .IRQ(irq));

   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk32(string nm, logic [31:0] e, logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Interrupt level, looked at once the edge's updates have landed
   task automatic chk_irq(logic e);
      @(negedge clk_sys);
      num_checks++;
      if (irq !== e) begin
         fails++;
         $display("ERROR irq expected %b seen %b", e, irq);
      end
   endtask

   task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
      @(posedge clk_sys);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk32(nm, e, q);
   endtask

   function automatic logic [31:0] ps(logic [2:0] c);
      return {28'h000_0000, c, 1'b0};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_regs();
      rd_chk("mode", pcm_pkg::ADDR_MODE, 32'h0000_0000);
      rd_chk("status", pcm_pkg::ADDR_STATUS, 32'h0000_0000);
      rd_chk("irq_en", pcm_pkg::ADDR_IRQ_EN, 32'h0000_0000);
      rd_chk("unmapped", 8'h18, 32'h0000_0000);
      chk32("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
      wr(pcm_pkg::ADDR_MODE, 32'h0000_00FF);
      rd_chk("mode_mask", pcm_pkg::ADDR_MODE, 32'h0000_008F);
      chk_irq(1'b0);
   endtask

   // Every source is stimulated at once; only the selected one may count
   task automatic run_src(logic [31:0] mode, logic id, int e);
      int n;
      n = 0;
      wr(pcm_pkg::ADDR_MODE, mode);
      idle <= id;
      for (int i = 0; i < 96; i++) begin
         @(posedge clk_sys);
         t0   <= (i < 64) && (i % 8 == 0);
         ext_count_input  <= (i < 64) ? ~i[1] : 1'b1;
         eclk <= (i < 64) ? i[1] : 1'b0;
         @(negedge clk_sys);
         if (tick === 1'b1) n++;
      end
      idle <= 1'b0;
      chk32("ticks", 32'(e), 32'(n));
   endtask

   task automatic test_src();
      run_src(ps(pcm_pkg::PS_CLK12), 1'b0, 96 / pcm_pkg::DIV_SLOW);
      run_src(ps(pcm_pkg::PS_CLK4), 1'b0, 96 / pcm_pkg::DIV_FAST);
      run_src(ps(pcm_pkg::PS_T0OVF), 1'b0, 8);
      run_src(ps(pcm_pkg::PS_EXTIN), 1'b0, 16);
      run_src(ps(pcm_pkg::PS_CLK), 1'b0, 96);
      run_src(ps(pcm_pkg::PS_EXT8), 1'b0, 16 / pcm_pkg::DIV_EXT);
      run_src(ps(pcm_pkg::PS_RSV6), 1'b0, 0);
      run_src(ps(pcm_pkg::PS_RSV7), 1'b0, 0);
      run_src(ps(pcm_pkg::PS_CLK), 1'b1, 96);
      run_src(ps(pcm_pkg::PS_CLK) | 32'h0000_0080, 1'b1, 0);
      run_src(ps(pcm_pkg::PS_EXTIN) | 32'h0000_0080, 1'b1, 0);
   endtask

   task automatic test_ovf();
      wr(pcm_pkg::ADDR_MODE, ps(pcm_pkg::PS_RSV6));
      wr(pcm_pkg::ADDR_IRQ_CLR, 32'h0000_0007);
      wr(pcm_pkg::ADDR_CONTROL, 32'h0000_FFFE);
      rd_chk("count", pcm_pkg::ADDR_COUNT, 32'h0000_FFFE);
      wr(pcm_pkg::ADDR_MODE, ps(pcm_pkg::PS_CLK));
      wr(pcm_pkg::ADDR_MODE, ps(pcm_pkg::PS_RSV6));
      rd_chk("status_ovf", pcm_pkg::ADDR_STATUS, 32'h0000_0001);
      chk32("count_value", 32'h0000_0001, {16'h0000, cval});
      chk_irq(1'b0);
      wr(pcm_pkg::ADDR_IRQ_EN, 32'h0000_0001);
      chk_irq(1'b0);
      wr(pcm_pkg::ADDR_MODE, ps(pcm_pkg::PS_RSV6) | 32'h0000_0001);
      chk_irq(1'b1);
      wr(pcm_pkg::ADDR_IRQ_CLR, 32'h0000_0001);
      rd_chk("status_clr", pcm_pkg::ADDR_STATUS, 32'h0000_0000);
      chk_irq(1'b0);
      wr(pcm_pkg::ADDR_MODE, ps(pcm_pkg::PS_RSV6));
   endtask

   task automatic test_match();
      @(posedge clk_sys);
      m0 <= 1'b1;
      @(posedge clk_sys);
      m0 <= 1'b0;
      repeat (20) @(posedge clk_sys);
      rd_chk("status_m0", pcm_pkg::ADDR_STATUS, 32'h0000_0002);
      chk_irq(1'b0);
      wr(pcm_pkg::ADDR_IRQ_EN, 32'h0000_0002);
      chk_irq(1'b1);
      wr(pcm_pkg::ADDR_IRQ_CLR, 32'h0000_0000);
      rd_chk("status_keep", pcm_pkg::ADDR_STATUS, 32'h0000_0002);
      @(posedge clk_sys);
      m1 <= 1'b1;
      @(posedge clk_sys);
      m1 <= 1'b0;
      rd_chk("status_m1", pcm_pkg::ADDR_STATUS, 32'h0000_0006);
      wr(pcm_pkg::ADDR_IRQ_CLR, 32'h0000_0002);
      rd_chk("status_c0", pcm_pkg::ADDR_STATUS, 32'h0000_0004);
      chk_irq(1'b0);
      wr(pcm_pkg::ADDR_IRQ_CLR, 32'h0000_0004);
      rd_chk("status_c1", pcm_pkg::ADDR_STATUS, 32'h0000_0000);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         fails++;
         summarize();
      end
   end

   initial begin
      repeat (4) @(posedge clk_sys);
      rst_b <= 1'b1;
      test_regs();
      test_src();
      test_ovf();
      test_match();
      summarize();
   end

endmodule // tb
